// [hw/uhef_consts.svh]
// Purpose: Offsets, field positions, reset values and timing counts of the host event flags.
// Assumes: A 200 MHz aclk.
// Notes:   Times are kept in their own unit; cycle counts derive from them.
`ifndef UHEF_CONSTS_SVH
`define UHEF_CONSTS_SVH

`define UHEF_ADDR_FLAGS     8'h00
`define UHEF_ADDR_XFER_STAT 8'h04
`define UHEF_ADDR_ERR_EN    8'h08
`define UHEF_ADDR_IRQ_STAT  8'h0C
`define UHEF_ADDR_IRQ_MASK  8'h10
`define UHEF_ADDR_CTRL      8'h14

`define UHEF_BIT_STALL  7
`define UHEF_BIT_ATTACH 6
`define UHEF_BIT_RESUME 5
`define UHEF_BIT_IDLE   4
`define UHEF_BIT_TOKEN  3
`define UHEF_BIT_SOF    2
`define UHEF_BIT_ERROR  1
`define UHEF_BIT_DETACH 0

`define UHEF_CTRL_HOST 0
`define UHEF_CTRL_LOW  1

`define UHEF_RST_BYTE 8'h00
`define UHEF_RST_CTRL 2'h1

`define UHEF_RESP_OKAY   2'h0
`define UHEF_RESP_SLVERR 2'h2

`define UHEF_CLK_PERIOD_PS 5000
`define UHEF_DWELL_TIME_NS 2500
`define UHEF_IDLE_TIME_US  3000
`define UHEF_DWELL_CYC \
  ((`UHEF_DWELL_TIME_NS * 1000 + `UHEF_CLK_PERIOD_PS - 1) / `UHEF_CLK_PERIOD_PS)
`define UHEF_IDLE_CYC \
  ((64'd`UHEF_IDLE_TIME_US * 64'd1000000 + 64'd4999) / 64'd`UHEF_CLK_PERIOD_PS)

`define UHEF_QUEUE_DEPTH 4
`endif

// [hw/uhef_dwell.sv]
// Purpose: Counts how long a condition has held and pulses once at the limit.
// Assumes: run drops for at least one cycle to restart the count.
// Notes:   The pulse fires a single time per unbroken run.
`timescale 1ns/1ps
module uhef_dwell #(
  parameter int WIDTH = 20
) (
  // Clock and reset.
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Condition and limit.
  input  wire logic             run,
  input  wire logic [WIDTH-1:0] limit,
  // One-cycle pulse.
  output logic                  hit
);
  logic [WIDTH-1:0] count_ff;
  wire              below_w = count_ff < limit;
  wire              last_w  = count_ff == (limit - WIDTH'(1));

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      count_ff <= '0;
      hit      <= 1'b0;
    end else begin
      count_ff <= below_w ? count_ff + WIDTH'(1) : count_ff;
      hit      <= last_w;
    end
  end
endmodule

// [hw/uhef_pkg.sv]
// Purpose: Types shared by the host event flag block.
// Assumes: Nothing beyond the constants header.
// Notes:   Line states follow the sampled D+ and D- pair.
package uhef_pkg;
  typedef enum logic [1:0] {
    UHEF_SE0 = 2'b00,
    UHEF_J   = 2'b01,
    UHEF_K   = 2'b10,
    UHEF_SE1 = 2'b11
  } uhef_line_type;
endpackage

// [hw/uhef_sync.sv]
// Purpose: Three-stage synchroniser for pin inputs.
// Assumes: Inputs may change at any time relative to aclk.
// Notes:   A change is accepted once the second and third stages agree.
`timescale 1ns/1ps
module uhef_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset.
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Pins and clean levels.
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  integer           i;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_ff     <= '0;
      s2_ff     <= '0;
      s3_ff     <= '0;
      level_out <= '0;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (s2_ff[i] == s3_ff[i]) begin
          level_out[i] <= s3_ff[i];
        end
      end
    end
  end
endmodule

// [hw/uhef_top.sv]
// Purpose: Host-role event flag register of a USB serial interface engine, on AXI4-Lite.
// Assumes: SIE event inputs are one-cycle pulses on aclk; D+ and D- come straight from pins.
// Notes:   Flags clear by writing ones with byte lanes 0 and 1 strobed; an interrupt status mirrors them, cleared on read.
// Summary of operation
// - Stall handshake from peripheral sets bit 7.
// - Non-SE0, quiet 2.5 us after SE0 sets attach.
// - K-state held 2.5 us sets resume bit.
// - Idle held 3 ms sets idle flag.
// - Token done sets bit 3, status readable.
// - Clearing token flag pops the status queue.
// - SOF received in peripheral role, or SOF threshold in host role, sets bit 2.
// - Only enabled errors set the error flag.
// - Peripheral disconnect sets the detach flag.
// - Writing one with byte lanes 0 and 1 strobed clears; zero keeps the bit.
// - Bits 15 to 8 read as zero.
// - Only hardware sets flags; reset clears them.
`timescale 1ns/1ps
`include "uhef_consts.svh"
module uhef_top #(
  parameter logic [19:0] IDLE_CYC = 20'(`UHEF_IDLE_CYC)
) (
  // Clock and reset.
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite write channels.
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read channels.
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // USB data lines.
  input  wire logic                  usb_dp,
  input  wire logic                  usb_dm,
  // SIE events.
  input  wire logic                  stall_hs_seen,
  input  wire logic                  token_done,
  input  wire logic [7:0]            token_status,
  output logic                       token_ready,
  input  wire logic                  sof_received,
  input  wire logic                  sof_threshold,
  input  wire logic [7:0]            error_events,
  // Interrupt.
  output logic                       irq
);
  import uhef_pkg::*;

  localparam logic [19:0] DWELL_CYC = 20'(`UHEF_DWELL_CYC);
  localparam int          QD        = `UHEF_QUEUE_DEPTH;

  logic [7:0]  flags_ff;
  logic [7:0]  err_en_ff;
  logic [7:0]  irq_stat_ff;
  logic [7:0]  irq_mask_ff;
  logic [1:0]  ctrl_ff;
  logic [7:0]  queue_ff [QD];
  logic [1:0]  rd_ptr_ff;
  logic [1:0]  wr_ptr_ff;
  logic [2:0]  count_ff;
  logic [7:0]  aw_addr_ff;
  logic        aw_held_ff;
  logic [31:0] w_data_ff;
  logic [3:0]  w_strb_ff;
  logic        w_held_ff;
  logic [1:0]  line_sync;
  uhef_line_type line_prev_ff;
  logic        armed_ff;
  logic        attached_ff;
  logic        attach_hit;
  logic        detach_hit;
  logic        resume_hit;
  logic        idle_hit;

  // Line state; J and K swap meaning at low speed.
  wire           low_w     = ctrl_ff[`UHEF_CTRL_LOW];
  wire           host_w    = ctrl_ff[`UHEF_CTRL_HOST];
  wire           se0_w     = line_sync == 2'b00;
  wire           se1_w     = line_sync == 2'b11;
  wire           fs_j_w    = line_sync == 2'b10;
  wire           is_j_w    = low_w ? (line_sync == 2'b01) : fs_j_w;
  wire uhef_line_type line_w = se0_w ? UHEF_SE0 : se1_w ? UHEF_SE1 :
                               is_j_w ? UHEF_J : UHEF_K;
  wire           change_w  = line_w != line_prev_ff;

  // Register bus decode.
  wire         wr_fire_w  = aw_held_ff & w_held_ff & ~s_axi_bvalid;
  wire         ar_fire_w  = s_axi_arvalid & s_axi_arready;
  wire         wa_flags_w = aw_addr_ff == `UHEF_ADDR_FLAGS;
  wire         wa_err_w   = aw_addr_ff == `UHEF_ADDR_ERR_EN;
  wire         wa_mask_w  = aw_addr_ff == `UHEF_ADDR_IRQ_MASK;
  wire         wa_ctrl_w  = aw_addr_ff == `UHEF_ADDR_CTRL;
  wire         wa_ro_w    = (aw_addr_ff == `UHEF_ADDR_XFER_STAT) ||
                            (aw_addr_ff == `UHEF_ADDR_IRQ_STAT);
  wire         wa_ok_w    = wa_flags_w | wa_err_w | wa_mask_w | wa_ctrl_w | wa_ro_w;
  wire         ra_flags_w = s_axi_araddr == `UHEF_ADDR_FLAGS;
  wire         ra_stat_w  = s_axi_araddr == `UHEF_ADDR_XFER_STAT;
  wire         ra_err_w   = s_axi_araddr == `UHEF_ADDR_ERR_EN;
  wire         ra_irq_w   = s_axi_araddr == `UHEF_ADDR_IRQ_STAT;
  wire         ra_mask_w  = s_axi_araddr == `UHEF_ADDR_IRQ_MASK;
  wire         ra_ctrl_w  = s_axi_araddr == `UHEF_ADDR_CTRL;
  wire         ra_ok_w    = ra_flags_w | ra_stat_w | ra_err_w | ra_irq_w | ra_mask_w | ra_ctrl_w;
  // The upper byte of the flag word holds no storage.
  wire [31:0]  rd_mux_w   = ra_flags_w ? {24'h00_0000, flags_ff} :
                            ra_stat_w  ? {24'h00_0000, queue_ff[rd_ptr_ff]} :
                            ra_err_w   ? {24'h00_0000, err_en_ff} :
                            ra_irq_w   ? {24'h00_0000, irq_stat_ff} :
                            ra_mask_w  ? {24'h00_0000, irq_mask_ff} :
                            ra_ctrl_w  ? {30'h0000_0000, ctrl_ff} : 32'h0000_0000;

  // Clears need both low byte lanes, so a write lacking either of them clears nothing.
  wire         whole_w    = s_axi_wstrb == 4'hF;
  wire         lane_ok_w  = w_strb_ff[1:0] == 2'b11;
  wire [7:0]   clr_w      = (wr_fire_w && wa_flags_w && lane_ok_w) ? w_data_ff[7:0] : 8'h00;
  wire         pop_w      = clr_w[`UHEF_BIT_TOKEN] & flags_ff[`UHEF_BIT_TOKEN] &
                            (count_ff != 3'd0);
  wire         push_w     = token_done & token_ready;

  // Event detection.
  wire [7:0]   set_w;
  assign set_w[`UHEF_BIT_STALL]  = stall_hs_seen;
  assign set_w[`UHEF_BIT_ATTACH] = attach_hit;
  assign set_w[`UHEF_BIT_RESUME] = resume_hit;
  assign set_w[`UHEF_BIT_IDLE]   = idle_hit;
  assign set_w[`UHEF_BIT_TOKEN]  = push_w | (pop_w & (count_ff > 3'd1));
  assign set_w[`UHEF_BIT_SOF]    = host_w ? sof_threshold : sof_received;
  assign set_w[`UHEF_BIT_ERROR]  = |(error_events & err_en_ff);
  assign set_w[`UHEF_BIT_DETACH] = detach_hit;

  // Set wins over clear so no event is lost.
  wire [7:0]   nxt_flags    = (flags_ff & ~clr_w) | set_w;
  wire         rd_irq_w     = ar_fire_w & ra_irq_w;
  wire [7:0]   nxt_irq_stat = (rd_irq_w ? 8'h00 : irq_stat_ff) | set_w;

  assign s_axi_awready = ~aw_held_ff & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_ff & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign token_ready   = count_ff != 3'(QD);

  uhef_sync #(.WIDTH(2)) u_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin_in    ({usb_dp, usb_dm}),
    .level_out (line_sync)
  );

  // Attach needs a preceding SE0, then a quiet non-SE0 line.
  uhef_dwell #(.WIDTH(20)) u_attach (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (armed_ff & ~se0_w & ~change_w),
    .limit   (DWELL_CYC),
    .hit     (attach_hit)
  );

  // A disconnected peripheral leaves SE0 from the pull-downs.
  uhef_dwell #(.WIDTH(20)) u_detach (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (attached_ff & se0_w),
    .limit   (DWELL_CYC),
    .hit     (detach_hit)
  );

  uhef_dwell #(.WIDTH(20)) u_resume (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (line_w == UHEF_K),
    .limit   (DWELL_CYC),
    .hit     (resume_hit)
  );

  uhef_dwell #(.WIDTH(20)) u_idle (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (line_w == UHEF_J),
    .limit   (IDLE_CYC),
    .hit     (idle_hit)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_prev_ff <= UHEF_SE0;
      armed_ff     <= 1'b0;
      attached_ff  <= 1'b0;
    end else begin
      line_prev_ff <= line_w;
      if (attach_hit) begin
        armed_ff    <= 1'b0;
        attached_ff <= 1'b1;
      end else if (detach_hit || (!attached_ff && se0_w)) begin
        armed_ff    <= 1'b1;
        attached_ff <= 1'b0;
      end
    end
  end

  // Flags start clear and only hardware events set them.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_ff    <= `UHEF_RST_BYTE;
      irq_stat_ff <= `UHEF_RST_BYTE;
      irq         <= 1'b0;
    end else begin
      flags_ff    <= nxt_flags;
      irq_stat_ff <= nxt_irq_stat;
      irq         <= |(nxt_irq_stat & irq_mask_ff);
    end
  end

  // Token status queue; the head is what software reads.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_ptr_ff <= 2'h0;
      wr_ptr_ff <= 2'h0;
      count_ff  <= 3'h0;
    end else begin
      if (push_w) begin
        queue_ff[wr_ptr_ff] <= token_status;
        wr_ptr_ff           <= wr_ptr_ff + 2'h1;
      end
      if (pop_w) begin
        rd_ptr_ff <= rd_ptr_ff + 2'h1;
      end
      count_ff <= count_ff + {2'h0, push_w} - {2'h0, pop_w};
    end
  end

  // Write channel holds address and data until both are in.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff   <= 1'b0;
      w_held_ff    <= 1'b0;
      aw_addr_ff   <= 8'h00;
      w_data_ff    <= 32'h0000_0000;
      w_strb_ff    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `UHEF_RESP_OKAY;
      err_en_ff    <= `UHEF_RST_BYTE;
      irq_mask_ff  <= `UHEF_RST_BYTE;
      ctrl_ff      <= `UHEF_RST_CTRL;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_ff <= s_axi_awaddr;
        aw_held_ff <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= whole_w ? 4'hF : s_axi_wstrb;
        w_held_ff <= 1'b1;
      end
      if (wr_fire_w) begin
        aw_held_ff   <= 1'b0;
        w_held_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wa_ok_w ? `UHEF_RESP_OKAY : `UHEF_RESP_SLVERR;
        if (wa_err_w && w_strb_ff[0]) begin
          err_en_ff <= w_data_ff[7:0];
        end
        if (wa_mask_w && w_strb_ff[0]) begin
          irq_mask_ff <= w_data_ff[7:0];
        end
        if (wa_ctrl_w && w_strb_ff[0]) begin
          ctrl_ff <= w_data_ff[1:0];
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `UHEF_RESP_OKAY;
    end else if (ar_fire_w) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux_w;
      s_axi_rresp  <= ra_ok_w ? `UHEF_RESP_OKAY : `UHEF_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence clear_write_s(int b);
    wr_fire_w && wa_flags_w && lane_ok_w && w_data_ff[b];
  endsequence

  stall_sets_a: assert property (stall_hs_seen |=> flags_ff[`UHEF_BIT_STALL])
    else $error("stall flag not set");
  attach_sets_a: assert property (attach_hit |=> flags_ff[`UHEF_BIT_ATTACH] && attached_ff)
    else $error("attach flag not set");
  resume_k_a: assert property (resume_hit |-> $past(line_w == UHEF_K) ##1
    flags_ff[`UHEF_BIT_RESUME])
    else $error("resume without K state");
  idle_sets_a: assert property (idle_hit |-> $past(line_w == UHEF_J) ##1
    flags_ff[`UHEF_BIT_IDLE])
    else $error("idle flag not set");
  token_push_a: assert property (push_w |=> flags_ff[`UHEF_BIT_TOKEN] && count_ff != 3'd0)
    else $error("token flag not set on push");
  token_pop_a: assert property (pop_w && count_ff > 3'd1 |=> flags_ff[`UHEF_BIT_TOKEN]
    && rd_ptr_ff == $past(rd_ptr_ff) + 2'h1)
    else $error("queue did not advance");
  sof_host_a: assert property (host_w && sof_threshold |=> flags_ff[`UHEF_BIT_SOF])
    else $error("sof flag not set in host role");
  err_masked_a: assert property (!(|(error_events & err_en_ff)) &&
    clr_w[`UHEF_BIT_ERROR] == 1'b0
    |=> flags_ff[`UHEF_BIT_ERROR] == $past(flags_ff[`UHEF_BIT_ERROR]))
    else $error("masked error changed flag");
  detach_sets_a: assert property (detach_hit |=> flags_ff[`UHEF_BIT_DETACH]
    && !attached_ff)
    else $error("detach flag not set");
  stall_clear_a: assert property (clear_write_s(`UHEF_BIT_STALL) and !stall_hs_seen
    |=> !flags_ff[`UHEF_BIT_STALL])
    else $error("stall flag not cleared");
  upper_zero_a: assert property (s_axi_rvalid && $past(ar_fire_w && ra_flags_w)
    |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper flag bits not zero");
  reset_clear_a: assert property (disable iff (1'b0) !aresetn |=> flags_ff == 8'h00)
    else $error("flags not clear after reset");
  set_wins_a: assert property (clear_write_s(`UHEF_BIT_STALL) and stall_hs_seen
    |=> flags_ff[`UHEF_BIT_STALL] [*2])
    else $error("event lost to clear");
  sof_peer_a: assert property (!host_w && sof_received |=> flags_ff[`UHEF_BIT_SOF])
    else $error("sof flag not set in peripheral role");
  partial_keep_a: assert property (wr_fire_w && wa_flags_w && !lane_ok_w
    |=> flags_ff == ($past(flags_ff) | $past(set_w)))
    else $error("partial write changed flags");
endmodule

// [test/uhef_periph_model.sv]
// Purpose: Behavioural model of the peripheral attached to the host's data lines.
// Assumes: The bench chooses the line state; low_speed mirrors the speed set in the block.
// Notes:   With no device driving, the host pull-downs leave both lines low.
`timescale 1ns/1ps
module uhef_periph_model (
  // Requested line state and device speed.
  input  wire uhef_pkg::uhef_line_type line_cmd,
  input  wire logic                    low_speed,
  // Data lines towards the host.
  output logic                         dp,
  output logic                         dm
);
  import uhef_pkg::*;
  // A low-speed device swaps the J and K levels, so one command serves both speeds.
  always_comb begin
    case (line_cmd)
      UHEF_J:   {dp, dm} = low_speed ? 2'b01 : 2'b10;
      UHEF_K:   {dp, dm} = low_speed ? 2'b10 : 2'b01;
      UHEF_SE1: {dp, dm} = 2'b11;
      default:  {dp, dm} = 2'b00;
    endcase
  end
endmodule

// [test/usb_host_event_flags_bench.sv]
// Purpose: Self-checking bench for the host event flags behind AXI4-Lite.
// Assumes: A short idle count of 50 cycles; the 2.5 us dwell stays at its full length.
// Notes:   After two fixed rounds, error enables and error events are drawn at random from a fixed seed.
`timescale 1ns/1ps
`include "uhef_consts.svh"
module usb_host_event_flags_bench;
  import uhef_pkg::*;
  logic          aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic          arvalid, arready, rvalid, rready, dp, dm, stall, tok_done, tok_rdy;
  logic          sof_rx, sof_th, irq, low_spd;
  logic [7:0]    awaddr, araddr, tok_st, err_ev;
  logic [31:0]   wdata, rdata, v, en, e;
  logic [3:0]    wstrb;
  logic [1:0]    bresp, rresp, resp;
  uhef_line_type line;
  int            miscompares, n_compared, seed, i;

  uhef_top #(.IDLE_CYC(20'd50)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .usb_dp(dp), .usb_dm(dm), .stall_hs_seen(stall), .token_done(tok_done),
    .token_status(tok_st), .token_ready(tok_rdy), .sof_received(sof_rx),
    .sof_threshold(sof_th), .error_events(err_ev), .irq(irq));
  uhef_periph_model peer (.line_cmd(line), .low_speed(low_spd), .dp(dp), .dm(dm));

  initial aclk = 1'b0;
  always #2.5 aclk = ~aclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Ready and response are sampled at the falling edge, where they have settled.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic pa = 1'b1, pw = 1'b1, pb = 1'b1, ta, tw;
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= s;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (pb) begin
      @(negedge aclk);
      ta = pa && awready;
      tw = pw && wready;
      pb = !bvalid;
      resp = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (!pb) bready <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
  endtask

  task automatic rd(input logic [7:0] a);
    logic pa = 1'b1, pr = 1'b1, ta;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (pr) begin
      @(negedge aclk);
      ta = pa && arready;
      pr = !rvalid;
      v = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (!pr) rready <= 1'b0;
      pa = pa && !ta;
    end
  endtask

  task automatic fl(input logic [31:0] exp);
    rd(`UHEF_ADDR_FLAGS);
    chk(v, exp);
  endtask

  task automatic clr_all;
    wr(`UHEF_ADDR_FLAGS, 32'hFFFF_FFFF, 4'hF);
  endtask

  task automatic chk_irq(input logic exp);
    @(negedge aclk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask

  // Event inputs are one-cycle pulses: stall, token done, frame received, frame threshold.
  task automatic ev(input logic [3:0] k, input logic [7:0] err, input logic [7:0] st);
    @(posedge aclk);
    {stall, tok_done, sof_rx, sof_th} <= k; err_ev <= err; tok_st <= st;
    @(posedge aclk);
    {stall, tok_done, sof_rx, sof_th} <= 4'h0; err_ev <= 8'h00;
  endtask

  task automatic hold(input uhef_line_type s, input int cyc);
    @(posedge aclk);
    line <= s;
    repeat (cyc) @(posedge aclk);
  endtask

  function automatic logic [31:0] exp_err(input logic [7:0] en, input logic [7:0] e);
    return {30'h0, |(en & e), 1'b0};
  endfunction

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge aclk);
    miscompares++;
    report_and_stop;
  end

  initial begin
    seed = 32'h4a91_2986;
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'h0;
    {stall, tok_done, sof_rx, sof_th} = 4'h0; err_ev = 8'h00; tok_st = 8'h00;
    line = UHEF_SE0; low_spd = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (10) @(posedge aclk);
    fl(32'h0);
    wr(`UHEF_ADDR_IRQ_MASK, 32'h0000_00FF, 4'hF);
    hold(UHEF_J, `UHEF_DWELL_CYC + 100);
    fl(32'h0000_0050);
    chk_irq(1'b1);
    hold(UHEF_K, `UHEF_DWELL_CYC + 100);
    fl(32'h0000_0070);
    wr(`UHEF_ADDR_FLAGS, 32'h0000_0040, 4'hF);
    fl(32'h0000_0030);
    wr(`UHEF_ADDR_FLAGS, 32'h0000_0030, 4'h1);
    fl(32'h0000_0030);
    clr_all;
    fl(32'h0);
    // A low-speed resume only shows if the design swaps J and K with the speed bit.
    hold(UHEF_J, 100);
    wr(`UHEF_ADDR_CTRL, 32'h0000_0003, 4'hF);
    low_spd <= 1'b1;
    hold(UHEF_J, 100);
    clr_all;
    hold(UHEF_K, `UHEF_DWELL_CYC + 100);
    fl(32'h0000_0020);
    wr(`UHEF_ADDR_CTRL, 32'h0000_0001, 4'hF);
    low_spd <= 1'b0;
    hold(UHEF_J, 20);
    clr_all;
    hold(UHEF_SE0, `UHEF_DWELL_CYC + 100);
    fl(32'h0000_0001);
    clr_all;
    wr(`UHEF_ADDR_IRQ_MASK, 32'h0, 4'hF);
    rd(`UHEF_ADDR_IRQ_STAT);
    ev(4'b1000, 8'h00, 8'h00);
    fl(32'h0000_0080);
    chk_irq(1'b0);
    wr(`UHEF_ADDR_IRQ_MASK, 32'h0000_0080, 4'hF);
    chk_irq(1'b1);
    rd(`UHEF_ADDR_IRQ_STAT);
    chk(v, 32'h0000_0080);
    chk_irq(1'b0);
    clr_all;
    ev(4'b0001, 8'h00, 8'h00);
    fl(32'h0000_0004);
    clr_all;
    wr(`UHEF_ADDR_CTRL, 32'h0, 4'hF);
    ev(4'b0010, 8'h00, 8'h00);
    fl(32'h0000_0004);
    clr_all;
    wr(`UHEF_ADDR_CTRL, 32'h0000_0001, 4'hF);
    ev(4'b0100, 8'h00, 8'h3A);
    ev(4'b0100, 8'h00, 8'hC5);
    fl(32'h0000_0008);
    rd(`UHEF_ADDR_XFER_STAT);
    chk(v, 32'h0000_003A);
    wr(`UHEF_ADDR_FLAGS, 32'h0000_0008, 4'hF);
    fl(32'h0000_0008);
    rd(`UHEF_ADDR_XFER_STAT);
    chk(v, 32'h0000_00C5);
    wr(`UHEF_ADDR_FLAGS, 32'h0000_0008, 4'hF);
    fl(32'h0);
    for (i = 0; i < 4; i++) ev(4'b0100, 8'h00, 8'(i + 16));
    @(negedge aclk);
    chk({31'h0, tok_rdy}, 32'h0);
    for (i = 0; i < 4; i++) begin
      rd(`UHEF_ADDR_XFER_STAT);
      chk(v, 32'(i + 16));
      wr(`UHEF_ADDR_FLAGS, 32'h0000_0008, 4'hF);
    end
    fl(32'h0);
    for (i = 0; i < 24; i++) begin
      en = $random(seed);
      e = $random(seed);
      if (i < 2) begin
        en = {24'h0, i[0], 7'h0};
        e = 32'h80;
      end
      wr(`UHEF_ADDR_ERR_EN, en, 4'hF);
      rd(`UHEF_ADDR_ERR_EN);
      chk(v, {24'h0, en[7:0]});
      ev(4'h0, e[7:0], 8'h00);
      fl(exp_err(en[7:0], e[7:0]));
      clr_all;
    end
    wr(8'h20, 32'h0000_00FF, 4'hF);
    chk({30'h0, resp}, {30'h0, `UHEF_RESP_SLVERR});
    rd(8'h20);
    chk(v, 32'h0);
    chk({30'h0, resp}, {30'h0, `UHEF_RESP_SLVERR});
    fl(32'h0);
    // The stall pulse lands on the very edge at which the clearing write takes effect.
    ev(4'b0001, 8'h00, 8'h00);
    fork
      clr_all;
      begin
        @(posedge aclk);
        ev(4'b1000, 8'h00, 8'h00);
      end
    join
    fl(32'h0000_0080);
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (10) @(posedge aclk);
    fl(32'h0);
    report_and_stop;
  end
endmodule
